// ---- hdl/clock_power_pkg.sv ----
// Constants, register map and field layout of the clock and power unit.
// Assumes a 32-bit AXI4-Lite register bus with one register per word.
package clock_power_pkg;
   // Register indices; the byte address is four times the index
   localparam logic [4:0] IDX_RESERVED_SLOT_ZERO = 5'h00;
   localparam logic [4:0] IDX_REGULATOR_TRIM_LOW = 5'h01;
   localparam logic [4:0] IDX_REGULATOR_TRIM_HIGH = 5'h02;
   localparam logic [4:0] IDX_RESET_CAUSE_FLAGS = 5'h03;
   localparam logic [4:0] IDX_PLL_MULTIPLIER = 5'h04;
   localparam logic [4:0] IDX_PLL_REFERENCE_DIVIDER = 5'h05;
   localparam logic [4:0] IDX_PLL_POST_DIVIDER = 5'h06;
   localparam logic [4:0] IDX_CLOCK_EVENT_FLAGS = 5'h07;
   localparam logic [4:0] IDX_CLOCK_INTERRUPT_ENABLES = 5'h08;
   localparam logic [4:0] IDX_CLOCK_SOURCE_SELECT = 5'h09;
   localparam logic [4:0] IDX_PLL_MODULATION_CONTROL = 5'h0a;
   localparam logic [4:0] IDX_PERIODIC_TIMER_RATE = 5'h0b;
   localparam logic [4:0] IDX_WATCHDOG_CONTROL = 5'h0c;
   localparam logic [4:0] IDX_FACTORY_TEST_ZERO = 5'h0d;
   localparam logic [4:0] IDX_WATCHDOG_SERVICE = 5'h10;
   localparam logic [4:0] IDX_IRQ_STATUS = 5'h11;
   localparam logic [4:0] IDX_IRQ_MASK = 5'h12;
   localparam logic [4:0] IDX_AUX_CONTROL = 5'h13;

   // Address split
   localparam int IDX_LSB = 2;
   localparam int IDX_MSB = 6;

   // Field positions
   localparam int POWER_FLAG_BIT = 6;
   localparam int LVRF_BIT = 5;
   localparam int WDRF_BIT = 3;
   localparam int RTIF_BIT = 7;
   localparam int FREEZE_BIT = 6;
   localparam int PERIOD_MSB = 2;
   localparam int RATE_MSB = 6;
   localparam int IRQ_TMR_BIT = 0;
   localparam int IRQ_WDOG_BIT = 1;
   localparam int IRQ_PIN_BIT = 2;
   localparam int IRQ_BITS = 3;

   // Reset values
   localparam logic [7:0] RST_ZERO = 8'h00;
   localparam logic [7:0] RST_RESET_FLAGS = 8'h40;
   localparam logic [7:0] RST_POST_DIVIDER = 8'h03;

   // Watchdog and timer shaping
   localparam logic [2:0] PERIOD_MAX = 3'h7;
   localparam logic [2:0] PERIOD_OFF = 3'h0;
   localparam int WDOG_WIDTH = 24;
   localparam int TMR_WIDTH = 16;
   localparam int TMR_PRESCALE_BITS = 9;

   // Reset pin drive time
   localparam int CLK_PERIOD_PS = 5000;
   localparam int RESET_DRIVE_NS = 1000;
   localparam int RESET_DRIVE_CYCLES =
      (RESET_DRIVE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int DRIVE_WIDTH = 8;

   // Bus answers
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   typedef struct packed
   {
      logic [3:0] spare;
      logic oscillator_enable;
      logic sense_voltage_select;
      logic periodic_output_source_select;
      logic periodic_output_enable;
   } aux_ctl_t;
endpackage

// ---- hdl/freeze_counter.sv ----
// Free-running up counter that can be held and restarted.
// Assumes one clock with a synchronous active-low reset and a clock enable.
`timescale 1ns/100ps
`default_nettype none
module freeze_counter
#(
   parameter int WIDTH = 16
)
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic hold,
   input wire logic restart,
   output logic [WIDTH-1:0] count
);
   logic [WIDTH-1:0] next_count;

   assign next_count = restart ? '0 : (hold ? count : count + 1'b1);

   always_ff @(posedge clk)
   begin
      if (!rst_n)
         count <= '0;
      else if (ce)
         count <= next_count;
   end
endmodule
`default_nettype wire

// ---- hdl/clock_power_unit.sv ----
// Clock and power unit slice: timer and watchdog freeze, reset pin,
// crystal path, periodic clock output, sense select and register map.
// Assumes AXI4-Lite on aclk and pins synchronous to aclk.
`timescale 1ns/100ps
`default_nettype none
module clock_power_unit
#(
   parameter int WDOG_BASE_BITS = 9
)
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic clk_en,
   input wire logic [31:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [31:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic debug_halt_mode,
   input wire logic power_on_event,
   input wire logic low_voltage_event,
   input wire logic reset_pin_in,
   output logic reset_pin_out,
   output logic reset_pin_oe,
   output logic system_reset_n,
   input wire logic crystal_input_pin,
   output logic oscillator_clock,
   output logic periodic_clock_output_pin,
   output logic periodic_clock_output_oe,
   output logic sense_voltage_select,
   output logic irq
);
   import clock_power_pkg::*;

   // Register storage
   logic [7:0] reset_cause_flags, pll_multiplier, pll_reference_divider;
   logic [7:0] pll_post_divider, clock_event_flags, clock_interrupt_enables;
   logic [7:0] clock_source_select, pll_modulation_control;
   logic [7:0] periodic_timer_rate, watchdog_control;
   logic [IRQ_BITS-1:0] irq_status, irq_mask;
   aux_ctl_t aux_ctl;

   // Bus holding registers
   logic aw_held, w_held, w_strb_q;
   logic [31:0] aw_addr_q;
   logic [7:0] w_data_q;

   // Bus decode
   wire aw_fire = s_axi_awvalid & s_axi_awready;
   wire w_fire = s_axi_wvalid & s_axi_wready;
   wire ar_fire = s_axi_arvalid & s_axi_arready;
   wire wr_go = aw_held & w_held & ~s_axi_bvalid;
   wire [4:0] wr_idx = aw_addr_q[IDX_MSB:IDX_LSB];
   wire [4:0] rd_idx = s_axi_araddr[IDX_MSB:IDX_LSB];
   wire wr_upper_zero = (aw_addr_q[31:IDX_MSB+1] == '0);
   wire rd_upper_zero = (s_axi_araddr[31:IDX_MSB+1] == '0);
   wire wr_en = wr_go & w_strb_q;
   wire [7:0] wd = w_data_q;

   function automatic logic idx_mapped(input logic [4:0] idx);
      idx_mapped = (idx <= IDX_FACTORY_TEST_ZERO) ||
         (idx >= IDX_WATCHDOG_SERVICE && idx <= IDX_AUX_CONTROL);
   endfunction

   wire wr_mapped = wr_upper_zero & idx_mapped(wr_idx);
   wire rd_mapped = rd_upper_zero & idx_mapped(rd_idx);
   wire wr_hit_flags = wr_en & wr_mapped & (wr_idx == IDX_RESET_CAUSE_FLAGS);
   wire wr_hit_events = wr_en & wr_mapped &
      (wr_idx == IDX_CLOCK_EVENT_FLAGS);
   wire wr_service = wr_go & wr_mapped & (wr_idx == IDX_WATCHDOG_SERVICE);
   wire rd_clear_irq = ar_fire & rd_mapped & (rd_idx == IDX_IRQ_STATUS);

   // Freeze and period selection
   wire freeze_req = watchdog_control[FREEZE_BIT];
   wire frozen = debug_halt_mode & freeze_req;
   // Outside the freeze both counters run as in normal run
   wire [2:0] cfg_period = watchdog_control[PERIOD_MSB:0];
   wire [2:0] eff_period = frozen ? PERIOD_MAX : cfg_period;
   wire wdog_enabled = (cfg_period != PERIOD_OFF);
   wire [5:0] wdog_shift = 6'(WDOG_BASE_BITS) + {2'b00, eff_period, 1'b0};
   wire [WDOG_WIDTH:0] wdog_one = (WDOG_WIDTH+1)'(1);
   wire [WDOG_WIDTH:0] wdog_limit_w = (wdog_one << wdog_shift) - wdog_one;
   wire [WDOG_WIDTH-1:0] wdog_limit = wdog_limit_w[WDOG_WIDTH-1:0];

   // Counters
   logic [WDOG_WIDTH-1:0] wdog_count;
   logic [TMR_WIDTH-1:0] tmr_count;
   logic sys_reset_q;
   wire [6:0] tmr_rate = periodic_timer_rate[RATE_MSB:0];
   wire tmr_enabled = (tmr_rate != '0);
   wire [TMR_WIDTH-1:0] tmr_limit = {tmr_rate, {TMR_PRESCALE_BITS{1'b1}}};
   wire tmr_tick = tmr_enabled & ~frozen & (tmr_count == tmr_limit);
   wire wdog_timeout = wdog_enabled & ~frozen & (wdog_count == wdog_limit);
   // Hold keeps the value; release resumes with no reload
   wire tmr_hold = frozen | ~tmr_enabled;
   wire wdog_hold = frozen | ~wdog_enabled;
   wire tmr_restart = tmr_tick | sys_reset_q;
   wire wdog_restart = wdog_timeout | wr_service | sys_reset_q;

   freeze_counter #(.WIDTH(TMR_WIDTH)) tmr_counter
   (
      .clk(aclk),
      .rst_n(aresetn),
      .ce(clk_en),
      .hold(tmr_hold),
      .restart(tmr_restart),
      .count(tmr_count)
   );

   freeze_counter #(.WIDTH(WDOG_WIDTH)) wdog_counter
   (
      .clk(aclk),
      .rst_n(aresetn),
      .ce(clk_en),
      .hold(wdog_hold),
      .restart(wdog_restart),
      .count(wdog_count)
   );

   // Reset pin handling
   logic [DRIVE_WIDTH-1:0] drive_count;
   wire internal_reset = wdog_timeout | power_on_event | low_voltage_event;
   wire pin_low = ~reset_pin_in;
   wire external_reset = pin_low & ~reset_pin_oe;
   wire [DRIVE_WIDTH-1:0] next_drive_count =
      internal_reset ? DRIVE_WIDTH'(RESET_DRIVE_CYCLES) :
      (drive_count != '0) ? drive_count - 1'b1 : drive_count;

   // Event bits
   logic [IRQ_BITS-1:0] irq_events;
   assign irq_events[IRQ_TMR_BIT] = tmr_tick;
   assign irq_events[IRQ_WDOG_BIT] = wdog_timeout;
   assign irq_events[IRQ_PIN_BIT] = external_reset;
   wire [IRQ_BITS-1:0] next_irq_status =
      irq_events | (rd_clear_irq ? '0 : irq_status);

   // Reset cause flags, write one to clear, set wins
   logic [7:0] flag_set;
   always_comb
   begin
      flag_set = RST_ZERO;
      flag_set[POWER_FLAG_BIT] = power_on_event;
      flag_set[LVRF_BIT] = low_voltage_event;
      flag_set[WDRF_BIT] = wdog_timeout;
   end
   wire [7:0] flag_clr = wr_hit_flags ? wd : RST_ZERO;
   wire [7:0] next_flags = flag_set | (reset_cause_flags & ~flag_clr);
   wire [7:0] event_set = 8'(tmr_tick) << RTIF_BIT;
   wire [7:0] event_clr = wr_hit_events ? wd : RST_ZERO;
   wire [7:0] next_events = event_set | (clock_event_flags & ~event_clr);

   // Read selection
   logic [7:0] rd_byte;
   always_comb
   begin
      case (rd_idx)
         IDX_RESET_CAUSE_FLAGS: rd_byte = reset_cause_flags;
         IDX_PLL_MULTIPLIER: rd_byte = pll_multiplier;
         IDX_PLL_REFERENCE_DIVIDER: rd_byte = pll_reference_divider;
         IDX_PLL_POST_DIVIDER: rd_byte = pll_post_divider;
         IDX_CLOCK_EVENT_FLAGS: rd_byte = clock_event_flags;
         IDX_CLOCK_INTERRUPT_ENABLES: rd_byte = clock_interrupt_enables;
         IDX_CLOCK_SOURCE_SELECT: rd_byte = clock_source_select;
         IDX_PLL_MODULATION_CONTROL: rd_byte = pll_modulation_control;
         IDX_PERIODIC_TIMER_RATE: rd_byte = periodic_timer_rate;
         IDX_WATCHDOG_CONTROL: rd_byte = watchdog_control;
         IDX_IRQ_STATUS: rd_byte = 8'(irq_status);
         IDX_IRQ_MASK: rd_byte = 8'(irq_mask);
         IDX_AUX_CONTROL: rd_byte = aux_ctl;
         default: rd_byte = RST_ZERO;
      endcase
   end
   wire [31:0] rd_word = rd_mapped ? {24'h00_0000, rd_byte} : 32'h0000_0000;

   // Clock output sources
   logic tmr_toggle;
   wire periodic_src = aux_ctl.periodic_output_source_select ?
      oscillator_clock : tmr_toggle;

   // Write channel acceptance
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr_q <= 32'h0000_0000;
         w_data_q <= RST_ZERO;
         w_strb_q <= 1'b0;
      end
      else if (clk_en)
      begin
         if (aw_fire)
         begin
            aw_held <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
         end
         else if (wr_go)
            aw_held <= 1'b0;
         if (w_fire)
         begin
            w_held <= 1'b1;
            w_data_q <= s_axi_wdata[7:0];
            w_strb_q <= s_axi_wstrb[0];
         end
         else if (wr_go)
            w_held <= 1'b0;
      end
   end

   // Bus answers
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rresp <= RESP_OKAY;
         s_axi_rdata <= 32'h0000_0000;
      end
      else if (clk_en)
      begin
         s_axi_awready <= ~aw_held & ~aw_fire & ~s_axi_bvalid & ~wr_go;
         s_axi_wready <= ~w_held & ~w_fire & ~s_axi_bvalid & ~wr_go;
         if (wr_go)
         begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
         end
         else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
         s_axi_arready <= ~s_axi_rvalid & ~ar_fire;
         if (ar_fire)
         begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
         end
         else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
      end
   end

   // Software registers
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         pll_multiplier <= RST_ZERO;
         pll_reference_divider <= RST_ZERO;
         pll_post_divider <= RST_POST_DIVIDER;
         clock_interrupt_enables <= RST_ZERO;
         clock_source_select <= RST_ZERO;
         pll_modulation_control <= RST_ZERO;
         periodic_timer_rate <= RST_ZERO;
         watchdog_control <= RST_ZERO;
         irq_mask <= '0;
         aux_ctl <= RST_ZERO;
      end
      else if (clk_en && wr_en && wr_mapped)
      begin
         case (wr_idx)
            IDX_PLL_MULTIPLIER: pll_multiplier <= wd;
            IDX_PLL_REFERENCE_DIVIDER: pll_reference_divider <= wd;
            IDX_PLL_POST_DIVIDER: pll_post_divider <= wd;
            IDX_CLOCK_INTERRUPT_ENABLES: clock_interrupt_enables <= wd;
            IDX_CLOCK_SOURCE_SELECT: clock_source_select <= wd;
            IDX_PLL_MODULATION_CONTROL: pll_modulation_control <= wd;
            IDX_PERIODIC_TIMER_RATE: periodic_timer_rate <= wd;
            IDX_WATCHDOG_CONTROL: watchdog_control <= wd;
            IDX_IRQ_MASK: irq_mask <= wd[IRQ_BITS-1:0];
            IDX_AUX_CONTROL: aux_ctl <= wd;
            default: ;
         endcase
      end
   end

   // Sticky flags; power-on sets the power-on flag
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         reset_cause_flags <= RST_RESET_FLAGS;
         clock_event_flags <= RST_ZERO;
         irq_status <= '0;
      end
      else if (clk_en)
      begin
         reset_cause_flags <= next_flags;
         clock_event_flags <= next_events;
         irq_status <= next_irq_status;
      end
   end

   // Reset pin and system reset
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         drive_count <= '0;
         reset_pin_out <= 1'b0;
         reset_pin_oe <= 1'b0;
         system_reset_n <= 1'b0;
         sys_reset_q <= 1'b0;
      end
      else if (clk_en)
      begin
         drive_count <= next_drive_count;
         reset_pin_oe <= (next_drive_count != '0);
         system_reset_n <= ~(pin_low | internal_reset);
         sys_reset_q <= pin_low;
      end
   end

   // Clock and analog selection outputs
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         oscillator_clock <= 1'b0;
         tmr_toggle <= 1'b0;
         periodic_clock_output_pin <= 1'b0;
         periodic_clock_output_oe <= 1'b0;
         sense_voltage_select <= 1'b0;
         irq <= 1'b0;
      end
      else if (clk_en)
      begin
         oscillator_clock <= aux_ctl.oscillator_enable & crystal_input_pin;
         if (tmr_tick)
            tmr_toggle <= ~tmr_toggle;
         periodic_clock_output_pin <= aux_ctl.periodic_output_enable &
            periodic_src;
         periodic_clock_output_oe <= aux_ctl.periodic_output_enable;
         sense_voltage_select <= aux_ctl.sense_voltage_select;
         irq <= |(next_irq_status & irq_mask);
      end
   end
endmodule
`default_nettype wire

// ---- bench/crystal_reset_model.sv ----
// Far-side model: free-running crystal and the pulled-up reset pin.
// Assumes pins are sampled on aclk; the test drives ext_reset_req.
`timescale 1ns/100ps
`default_nettype none
module crystal_reset_model
(
   input wire logic aclk,
   input wire logic reset_pin_out,
   input wire logic reset_pin_oe,
   input wire logic ext_reset_req,
   output logic crystal_input_pin,
   output logic reset_pin_in
);
   initial crystal_input_pin = 1'b0;
   // Resonator runs free at half the bus clock
   always @(posedge aclk)
   begin
      crystal_input_pin <= !crystal_input_pin;
   end
   // Pull-up unless the unit or outside circuitry pulls low
   assign reset_pin_in = (reset_pin_oe ? reset_pin_out : 1'b1) &
      !ext_reset_req;
endmodule
`default_nettype wire

// ---- bench/clock_power_unit_checker.sv ----
// Port checker for the clock and power unit, bound to its top.
// Assumes one aclk domain with synchronous active-low reset.
`timescale 1ns/100ps
`default_nettype none
module clock_power_unit_checker
#(
   parameter int WDOG_BASE_BITS = 9
)
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic clk_en,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic power_on_event,
   input wire logic low_voltage_event,
   input wire logic reset_pin_in,
   input wire logic reset_pin_out,
   input wire logic reset_pin_oe,
   input wire logic system_reset_n,
   input wire logic crystal_input_pin,
   input wire logic oscillator_clock,
   input wire logic periodic_clock_output_pin,
   input wire logic periodic_clock_output_oe,
   input wire logic irq
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   a_pin_open_drain: assert property (reset_pin_oe |-> !reset_pin_out)
      else $error("reset pin driven high");
   a_por_drives_pin: assert property (clk_en && power_on_event |=> reset_pin_oe)
      else $error("power-on did not drive pin");
   a_lvr_drives_pin: assert property (clk_en && low_voltage_event |=> reset_pin_oe)
      else $error("low voltage did not drive pin");
   a_pin_resets_chip: assert property (clk_en && !reset_pin_in |=> !system_reset_n)
      else $error("low pin did not reset");
   a_osc_from_crystal: assert property ($rose(oscillator_clock) |-> $past(crystal_input_pin))
      else $error("oscillator clock not from crystal");
   a_extclk_gated: assert property ($rose(periodic_clock_output_pin) |-> periodic_clock_output_oe || $past(periodic_clock_output_oe))
      else $error("clock output while disabled");
   a_read_answer: assert property (clk_en && s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read not answered");
   a_read_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");
   a_write_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write response dropped");
   a_irq_after_reset: assert property ($rose(aresetn) |-> !irq)
      else $error("irq high out of reset");
   c_write: cover property (s_axi_bvalid && s_axi_bready);
   c_read: cover property (s_axi_rvalid && s_axi_rready);
   c_irq: cover property ($rose(irq));
   c_pin_free: cover property ($fell(reset_pin_oe));
endmodule
bind clock_power_unit clock_power_unit_checker
   #(.WDOG_BASE_BITS(WDOG_BASE_BITS)) chk (.aclk, .aresetn, .clk_en,
   .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
   .s_axi_rready, .s_axi_bvalid, .s_axi_bready, .power_on_event,
   .low_voltage_event, .reset_pin_in, .reset_pin_out, .reset_pin_oe,
   .system_reset_n, .crystal_input_pin, .oscillator_clock,
   .periodic_clock_output_pin, .periodic_clock_output_oe, .irq);
`default_nettype wire

// ---- bench/clock_power_unit_tb.sv ----
// Self-checking bench for the clock and power unit.
// Assumes the far-side model and the bound port checker.
`timescale 1ns/100ps
`default_nettype none
module clock_power_unit_tb;
   import clock_power_pkg::*;
   logic aclk, aresetn, clk_en, debug_halt_mode, power_on_event;
   logic low_voltage_event, reset_pin_in, reset_pin_out, reset_pin_oe;
   logic system_reset_n, crystal_input_pin, oscillator_clock, irq;
   logic periodic_clock_output_pin, periodic_clock_output_oe;
   logic sense_voltage_select, ext_reset_req;
   logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic s_axi_rvalid, s_axi_rready;
   int n_mismatch = 0;
   int check_count = 0;
   logic [31:0] d;
   logic [1:0] r;
   int n;

   clock_power_unit #(.WDOG_BASE_BITS(2)) uut (.aclk, .aresetn, .clk_en,
      .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .debug_halt_mode, .power_on_event,
      .low_voltage_event, .reset_pin_in, .reset_pin_out, .reset_pin_oe,
      .system_reset_n, .crystal_input_pin, .oscillator_clock,
      .periodic_clock_output_pin, .periodic_clock_output_oe,
      .sense_voltage_select, .irq);
   crystal_reset_model far (.aclk, .reset_pin_out, .reset_pin_oe,
      .ext_reset_req, .crystal_input_pin, .reset_pin_in);

   initial aclk = 1'b0;
   always #2.5 aclk = !aclk;

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic cyc(input int k);
      repeat (k) @(posedge aclk);
   endtask

   task automatic wr(input logic [4:0] i, input logic [7:0] v,
      output logic [1:0] rs);
      logic aw_ok, w_ok;
      aw_ok = 1'b0;
      w_ok = 1'b0;
      @(posedge aclk);
      s_axi_awaddr <= {25'h0, i, 2'h0};
      s_axi_wdata <= {24'h0, v};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!(aw_ok && w_ok))
      begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_ok = 1'b1;
            s_axi_awvalid <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_ok = 1'b1;
            s_axi_wvalid <= 1'b0;
         end
      end
      do @(posedge aclk); while (!s_axi_bvalid);
      rs = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask

   task automatic rd(input logic [4:0] i, output logic [31:0] v,
      output logic [1:0] rs);
      @(posedge aclk);
      s_axi_araddr <= {25'h0, i, 2'h0};
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge aclk); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      do @(posedge aclk); while (!s_axi_rvalid);
      v = s_axi_rdata;
      rs = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask

   task automatic t_map;
      for (int k = 0; k < 20; k++)
      begin
         rd(k[4:0], d, r);
         check(d, k == 3 ? 32'h40 : k == 6 ? 32'h3 : 32'h0);
         check(r, (k == 14 || k == 15) ? RESP_SLVERR : RESP_OKAY);
      end
      wr(IDX_REGULATOR_TRIM_LOW, 8'hff, r);
      rd(IDX_REGULATOR_TRIM_LOW, d, r);
      check(d, 32'h0);
      wr(IDX_PLL_MULTIPLIER, 8'h5a, r);
      rd(IDX_PLL_MULTIPLIER, d, r);
      check(d, 32'h5a);
      wr(5'h0e, 8'h01, r);
      check(r, RESP_SLVERR);
      $display("t_map done");
   endtask

   task automatic t_flags;
      for (int k = 0; k < 2; k++)
      begin
         wr(IDX_RESET_CAUSE_FLAGS, 8'h60, r);
         rd(IDX_RESET_CAUSE_FLAGS, d, r);
         check(d & 32'h60, 32'h0);
         if (k == 0)
            power_on_event <= 1'b1;
         else
            low_voltage_event <= 1'b1;
         cyc(3);
         check(reset_pin_oe, 1'b1);
         check(system_reset_n, 1'b0);
         power_on_event <= 1'b0;
         low_voltage_event <= 1'b0;
         cyc(250);
         check(reset_pin_oe, 1'b0);
         wr(IDX_RESET_CAUSE_FLAGS, 8'h00, r);
         rd(IDX_RESET_CAUSE_FLAGS, d, r);
         check(d & 32'h60, k == 0 ? 32'h40 : 32'h20);
      end
      $display("t_flags done");
   endtask

   task automatic t_pin;
      wr(IDX_RESET_CAUSE_FLAGS, 8'h60, r);
      wr(IDX_IRQ_MASK, 8'h04, r);
      for (int k = 0; k < 2; k++)
      begin
         ext_reset_req <= 1'b1;
         cyc(4);
         check(system_reset_n, 1'b0);
         ext_reset_req <= 1'b0;
         cyc(10);
         check(irq, k == 0);
         rd(IDX_IRQ_STATUS, d, r);
         check(d, 32'h4);
         cyc(2);
         check(irq, 1'b0);
         wr(IDX_IRQ_MASK, 8'h00, r);
      end
      rd(IDX_RESET_CAUSE_FLAGS, d, r);
      check(d & 32'h40, 32'h0);
      $display("t_pin done");
   endtask

   task automatic wait_irq(output int c);
      c = 0;
      while (irq !== 1'b1 && c < 40)
      begin
         @(posedge aclk);
         c++;
      end
   endtask

   task automatic t_wdog;
      wr(IDX_IRQ_MASK, 8'h02, r);
      wr(IDX_WATCHDOG_CONTROL, 8'h01, r);
      debug_halt_mode <= 1'b1;
      wait_irq(n);
      check(n < 40, 1'b1);
      wr(IDX_WATCHDOG_CONTROL, 8'h41, r);
      rd(IDX_IRQ_STATUS, d, r);
      cyc(220);
      check(irq, 1'b0);
      debug_halt_mode <= 1'b0;
      wr(IDX_WATCHDOG_SERVICE, 8'h00, r);
      rd(IDX_IRQ_STATUS, d, r);
      cyc(6);
      debug_halt_mode <= 1'b1;
      cyc(60);
      check(irq, 1'b0);
      debug_halt_mode <= 1'b0;
      wait_irq(n);
      check(n < 12, 1'b1);
      wr(IDX_WATCHDOG_CONTROL, 8'h00, r);
      cyc(220);
      rd(IDX_RESET_CAUSE_FLAGS, d, r);
      check(d & 32'h08, 32'h08);
      wr(IDX_IRQ_MASK, 8'h00, r);
      $display("t_wdog done");
   endtask

   task automatic t_aux;
      logic [7:0] cfg[5] = '{8'h00, 8'h08, 8'h0b, 8'h0a, 8'h04};
      int h0, h1;
      for (int k = 0; k < 5; k++)
      begin
         wr(IDX_AUX_CONTROL, cfg[k], r);
         cyc(4);
         h0 = 0;
         h1 = 0;
         repeat (8)
         begin
            @(posedge aclk);
            h0 += oscillator_clock;
            h1 += periodic_clock_output_pin;
         end
         check(h0, cfg[k][3] ? 4 : 0);
         check(h1, (cfg[k][0] & cfg[k][1] & cfg[k][3]) ? 4 : 0);
         check(periodic_clock_output_oe, cfg[k][0]);
         check(sense_voltage_select, cfg[k][2]);
      end
      $display("t_aux done");
   endtask

   task automatic t_tick;
      rd(IDX_IRQ_STATUS, d, r);
      wr(IDX_IRQ_MASK, 8'h01, r);
      wr(IDX_AUX_CONTROL, 8'h01, r);
      wr(IDX_PERIODIC_TIMER_RATE, 8'h01, r);
      cyc(1000);
      check(irq, 1'b0);
      check(periodic_clock_output_pin, 1'b0);
      cyc(40);
      check(irq, 1'b1);
      check(periodic_clock_output_pin, 1'b1);
      rd(IDX_CLOCK_EVENT_FLAGS, d, r);
      check(d, 32'h80);
      wr(IDX_PERIODIC_TIMER_RATE, 8'h00, r);
      $display("t_tick done");
   endtask

   task automatic results;
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   initial
   begin
      aresetn = 1'b0;
      clk_en = 1'b1;
      {debug_halt_mode, power_on_event, low_voltage_event} = 3'h0;
      ext_reset_req = 1'b0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
      {s_axi_arvalid, s_axi_rready} = 2'h0;
      {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 96'h0;
      s_axi_wstrb = 4'hf;
      cyc(12);
      aresetn <= 1'b1;
      cyc(2);
      t_map;
      t_flags;
      t_pin;
      t_wdog;
      t_aux;
      t_tick;
      results;
   end

   initial
   begin
      #100000;
      n_mismatch++;
      results;
   end
endmodule
`default_nettype wire
